// ===== core/pcb_pkg.sv
package pcb_pkg;
  // Number of pins held in this bank.
  localparam int NPIN = 9;
  // Register indices; the byte address of each is four times its index.
  localparam logic [6:0] IDX_PIN_1_6    = 7'h29;
  localparam logic [6:0] IDX_PIN_1_7    = 7'h2a;
  localparam logic [6:0] IDX_PIN_2_0    = 7'h2b;
  localparam logic [6:0] IDX_PIN_2_1    = 7'h2c;
  localparam logic [6:0] IDX_PIN_2_2    = 7'h2d;
  localparam logic [6:0] IDX_RESERVED   = 7'h2e;
  localparam logic [6:0] IDX_PIN_2_4    = 7'h2f;
  localparam logic [6:0] IDX_PIN_2_5    = 7'h30;
  localparam logic [6:0] IDX_PIN_2_6    = 7'h31;
  localparam logic [6:0] IDX_PIN_2_7    = 7'h32;
  localparam logic [6:0] IDX_OUT_DATA   = 7'h40;
  localparam logic [6:0] IDX_IN_STATE   = 7'h41;
  localparam logic [6:0] IDX_INT_STATUS = 7'h42;
  localparam logic [6:0] IDX_INT_MASK   = 7'h43;
  // Index of each pin slot, in slot order.
  localparam logic [6:0] PIN_IDX [NPIN] = '{IDX_PIN_1_6, IDX_PIN_1_7, IDX_PIN_2_0,
    IDX_PIN_2_1, IDX_PIN_2_2, IDX_PIN_2_4, IDX_PIN_2_5, IDX_PIN_2_6, IDX_PIN_2_7};
  // Slot numbers that need special treatment.
  localparam int SLOT_1_6 = 0;
  localparam int SLOT_1_7 = 1;
  localparam int SLOT_2_0 = 2;
  localparam int SLOT_2_1 = 3;
  localparam int SLOT_2_2 = 4;
  localparam int SLOT_2_4 = 5;
  localparam int SLOT_2_5 = 6;
  localparam int SLOT_2_6 = 7;
  localparam int SLOT_2_7 = 8;
  localparam logic [3:0] SLOT_NONE = 4'hf;
  // Field positions inside a pin configuration byte.
  localparam int BIT_DIR    = 0;
  localparam int BIT_POL    = 1;
  localparam int BIT_SEL    = 2;
  localparam int BIT_SEL_HI = 3;
  localparam int BIT_OTYPE  = 7;
  // Reset value and writable-bit masks of a configuration byte.
  localparam logic [7:0] CFG_RESET  = 8'h01;
  localparam logic [7:0] MASK_STD   = 8'h87;
  localparam logic [7:0] MASK_WIDE  = 8'h8f;
  localparam logic [7:0] MASK_NOALT = 8'h83;
  // Bus responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Pin function as decoded from the selector field.
  typedef enum logic [1:0] {
    PCB_FN_GPIO   = 2'b00,
    PCB_FN_KBC    = 2'b01,
    PCB_FN_EDGE   = 2'b10,
    PCB_FN_FLOPPY = 2'b11
  } pcb_fn_t;
endpackage

// ===== core/pcb_top.sv
`timescale 1ns/1ns
// Functional notes
// RULE1: Direction bit one means input, zero output.
// RULE2: Polarity bit one inverts the pin value.
// RULE3: Output-type bit one gives open drain.
// RULE4: Single selector bit one routes alternate function.
// RULE5: Pin 2.1 selector picks floppy, edge, keyboard.
// RULE6: Pin 2.2 selector picks motor, edge, keyboard.
// RULE7: Reserved slot between 2.2 and 2.4 reads zero.
// RULE8: Pin 2.4 has no alternate function.
// RULE9: Pin 2.5 alternate feeds the MIDI receiver.
// RULE10: Pin 2.6 alternate driven by MIDI transmitter.
// RULE11: Pin 2.0 alternate is keyboard port bit seven.
// RULE12: Pin 1.6 alternate is joystick two X.
// RULE13: Pin 1.7 alternate is joystick two Y.
// RULE14: Reserved configuration bits ignore writes, read zero.
// RULE15: Reset loads input, no invert, GPIO, push-pull.
module pcb_top import pcb_pkg::*; #(
  parameter int ADDR_W = 12
) (
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [NPIN-1:0]   pin_in,
  output logic [NPIN-1:0]        pin_out,
  output logic [NPIN-1:0]        pin_oe,
  input  wire logic              kbc_port_bit7_out,
  input  wire logic              kbc_port_bit6_out,
  input  wire logic              kbc_port_bit2_out,
  input  wire logic              floppy_drive_select_one_n,
  input  wire logic              floppy_motor_select_one_n,
  input  wire logic              midi_transmit,
  input  wire logic              pin_2_7_alt_out,
  output logic                   kbc_port_bit7_in,
  output logic                   kbc_port_bit6_in,
  output logic                   kbc_port_bit2_in,
  output logic                   joystick_two_x_axis,
  output logic                   joystick_two_y_axis,
  output logic                   midi_receive,
  output logic                   pin_2_7_alt_in,
  output logic                   irq
);

  // Every assertion below samples on the rising clock and rests during reset.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // Slot number of a configuration index, or SLOT_NONE.
  function automatic logic [3:0] slot_of(input logic [6:0] idx);
    logic [3:0] s;
    s = SLOT_NONE;
    for (int k = 0; k < NPIN; k++) begin
      if (PIN_IDX[k] == idx) begin
        s = 4'(k);
      end
    end
    return s;
  endfunction

  // Writable bits of each slot; everything else is reserved.
  function automatic logic [7:0] wmask(input int k);
    if (k == SLOT_2_1 || k == SLOT_2_2) begin
      return MASK_WIDE;
    end else if (k == SLOT_2_4) begin
      return MASK_NOALT;
    end else begin
      return MASK_STD;
    end
  endfunction

  // True for every index the slave answers with OKAY.
  function automatic logic is_mapped(input logic [6:0] idx);
    return (slot_of(idx) != SLOT_NONE) || idx == IDX_RESERVED || idx == IDX_OUT_DATA ||
           idx == IDX_IN_STATE || idx == IDX_INT_STATUS || idx == IDX_INT_MASK;
  endfunction

  logic [7:0]      cfg [NPIN];   // Pin configuration bytes.
  pcb_fn_t         fn [NPIN];    // Decoded function of each pin.
  logic [NPIN-1:0] out_data;     // Software output value of each pin.
  logic [1:0]      int_status;   // Sticky edge-interrupt events.
  logic [1:0]      int_mask;     // Enables of the status bits onto irq.
  logic [NPIN-1:0] sync_meta;    // First synchroniser stage; read only by sync_pin.
  logic [NPIN-1:0] sync_pin;     // Pin levels in the clock domain.
  logic [NPIN-1:0] prev_pin;     // Last cycle's synchronised level, for edges.
  logic [NPIN-1:0] in_val;       // Synchronised level after polarity.
  logic [NPIN-1:0] alt_src;      // Peripheral value offered to each pin.
  logic [NPIN-1:0] next_out;     // Pad data for the coming cycle.
  logic [NPIN-1:0] next_oe;      // Pad enable for the coming cycle.
  logic [1:0]      edge_evt;     // Either-edge events on pins 2.1 and 2.2.
  logic [1:0]      next_status;  // Status after set and clear.
  logic            have_aw;      // Write address held.
  logic            have_w;       // Write data held.
  logic [ADDR_W-1:0] wr_addr;    // Held write address.
  logic [31:0]     wr_data;      // Held write data.
  logic [3:0]      wr_strb;      // Held byte strobes.
  logic [6:0]      wr_idx;       // Register index of the held write.
  logic            wr_ok;        // Held write lands on a mapped register.
  logic            wr_fire;      // Write performed this cycle.
  logic [6:0]      rd_idx;       // Register index of the read request.
  logic [31:0]     rd_word;      // Read data for that index.

  // Two flops stand between each pad and any logic, since pads are asynchronous.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync_meta <= '0;
      sync_pin  <= '0;
      prev_pin  <= '0;
    end else begin
      sync_meta <= pin_in;
      sync_pin  <= sync_meta;
      prev_pin  <= sync_pin;
    end
  end

  // Per-pin decode of function, input value and pad drive.
  for (genvar k = 0; k < NPIN; k++) begin : g_pin
    logic src;
    logic val;
    always_comb begin
      if (k == SLOT_2_1 || k == SLOT_2_2) begin
        fn[k] = pcb_fn_t'(cfg[k][BIT_SEL_HI:BIT_SEL]); // RULE5 RULE6
      end else if (k == SLOT_2_4) begin
        fn[k] = PCB_FN_GPIO; // RULE8
      end else begin
        fn[k] = pcb_fn_t'({1'b0, cfg[k][BIT_SEL]}); // RULE4
      end
    end
    assign in_val[k] = sync_pin[k] ^ cfg[k][BIT_POL]; // RULE2
    // Alternate routing replaces the software value as the drive source.
    assign src = (fn[k] != PCB_FN_GPIO) ? alt_src[k] : out_data[k]; // RULE4
    assign val = src ^ cfg[k][BIT_POL]; // RULE2
    // Open drain only ever pulls low; a high value releases the pad.
    assign next_out[k] = cfg[k][BIT_OTYPE] ? 1'b0 : val; // RULE3
    assign next_oe[k]  = !cfg[k][BIT_DIR] && (!cfg[k][BIT_OTYPE] || !val); // RULE1 RULE3

    chk_reserved_bits: assert property ((cfg[k] & ~wmask(k)) == 8'h00) // RULE14
      else $error("reserved configuration bit set");
    chk_dir_input: assert property (cfg[k][BIT_DIR] |=> !pin_oe[k]) // RULE1
      else $error("input pin is driven");
    chk_push_pull: assert property (!cfg[k][BIT_DIR] && !cfg[k][BIT_OTYPE] // RULE3
      |=> pin_oe[k])
      else $error("push-pull output not driven");
    chk_od_low: assert property (cfg[k][BIT_OTYPE] |=> !pin_out[k] && // RULE3
      (pin_oe[k] == ($past(cfg[k][BIT_DIR]) == 1'b0 && $past(val) == 1'b0)))
      else $error("open drain drive wrong");
    chk_gpio_polarity: assert property (fn[k] == PCB_FN_GPIO && !cfg[k][BIT_OTYPE] // RULE2
      |=> pin_out[k] == ($past(out_data[k]) ^ $past(cfg[k][BIT_POL])))
      else $error("gpio output polarity wrong");
  end

  // Peripheral outputs offered to the pins that can carry them.
  always_comb begin
    alt_src           = '0;
    alt_src[SLOT_2_0] = kbc_port_bit7_out; // RULE11
    // Pin 2.1 carries the drive select in the floppy mode, else the keyboard bit.
    alt_src[SLOT_2_1] = (fn[SLOT_2_1] == PCB_FN_FLOPPY) ? floppy_drive_select_one_n
                                                        : kbc_port_bit6_out; // RULE5
    alt_src[SLOT_2_2] = (fn[SLOT_2_2] == PCB_FN_FLOPPY) ? floppy_motor_select_one_n
                                                        : kbc_port_bit2_out; // RULE6
    alt_src[SLOT_2_6] = midi_transmit; // RULE10
    alt_src[SLOT_2_7] = pin_2_7_alt_out;
  end

  // Pads update once a cycle so every pad output comes from a flop.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_out <= '0;
      pin_oe  <= '0;
    end else begin
      pin_out <= next_out;
      pin_oe  <= next_oe;
    end
  end

  // Inputs routed to peripherals; an unrouted input holds its idle level.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      joystick_two_x_axis <= 1'b0;
      joystick_two_y_axis <= 1'b0;
      kbc_port_bit7_in    <= 1'b0;
      kbc_port_bit6_in    <= 1'b0;
      kbc_port_bit2_in    <= 1'b0;
      midi_receive        <= 1'b1;
      pin_2_7_alt_in      <= 1'b0;
    end else begin
      joystick_two_x_axis <= (fn[SLOT_1_6] != PCB_FN_GPIO) && in_val[SLOT_1_6]; // RULE12
      joystick_two_y_axis <= (fn[SLOT_1_7] != PCB_FN_GPIO) && in_val[SLOT_1_7]; // RULE13
      kbc_port_bit7_in    <= (fn[SLOT_2_0] != PCB_FN_GPIO) && in_val[SLOT_2_0]; // RULE11
      kbc_port_bit6_in    <= (fn[SLOT_2_1] == PCB_FN_KBC) && in_val[SLOT_2_1]; // RULE5
      kbc_port_bit2_in    <= (fn[SLOT_2_2] == PCB_FN_KBC) && in_val[SLOT_2_2]; // RULE6
      // MIDI idles at mark, so an unrouted receiver sees a quiet line.
      midi_receive        <= (fn[SLOT_2_5] == PCB_FN_GPIO) || in_val[SLOT_2_5]; // RULE9
      pin_2_7_alt_in      <= (fn[SLOT_2_7] != PCB_FN_GPIO) && in_val[SLOT_2_7];
    end
  end

  // Either-edge interrupt inputs; raw levels are compared so a polarity change
  // does not fake an edge.
  assign edge_evt[0] = (fn[SLOT_2_1] == PCB_FN_EDGE) &&
                       (sync_pin[SLOT_2_1] != prev_pin[SLOT_2_1]); // RULE5
  assign edge_evt[1] = (fn[SLOT_2_2] == PCB_FN_EDGE) &&
                       (sync_pin[SLOT_2_2] != prev_pin[SLOT_2_2]); // RULE6

  // Write-one-to-clear; a new event in the clearing cycle is kept.
  always_comb begin
    next_status = int_status;
    // A refused write must not clear anything, so the mapped check is needed here too.
    if (wr_fire && wr_ok && wr_idx == IDX_INT_STATUS && wr_strb[0]) begin
      next_status = int_status & ~wr_data[1:0];
    end
    next_status = next_status | edge_evt;
  end

  // Status, and the interrupt level taken from the next status.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      int_status <= 2'h0;
      irq        <= 1'b0;
    end else begin
      int_status <= next_status;
      irq        <= |(next_status & int_mask);
    end
  end

  // Write channel capture; address and data are taken in either order.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      have_aw       <= 1'b0;
      have_w        <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      wr_addr       <= '0;
      wr_data       <= 32'h0;
      wr_strb       <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        have_aw       <= 1'b1;
        s_axi_awready <= 1'b0;
        wr_addr       <= s_axi_awaddr;
      end else if (wr_fire) begin
        have_aw <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        have_w       <= 1'b1;
        s_axi_wready <= 1'b0;
        wr_data      <= s_axi_wdata;
        wr_strb      <= s_axi_wstrb;
      end else if (wr_fire) begin
        have_w <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_wready <= 1'b1;
      end
    end
  end

  assign wr_idx  = wr_addr[8:2];
  assign wr_ok   = (wr_addr[ADDR_W-1:9] == '0) && is_mapped(wr_idx);
  assign wr_fire = have_aw && have_w && !s_axi_bvalid;

  // Write response one cycle after both halves are held.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Register updates; nrst low restores the defaults.
  for (genvar k = 0; k < NPIN; k++) begin : g_cfg
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        cfg[k] <= CFG_RESET; // RULE15
      end else if (wr_fire && wr_ok && wr_strb[0] && slot_of(wr_idx) == 4'(k)) begin
        cfg[k] <= wr_data[7:0] & wmask(k); // RULE14 RULE8
      end
    end
  end

  // Software output value and interrupt mask.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      out_data <= '0;
      int_mask <= 2'h0;
    end else if (wr_fire && wr_ok) begin
      if (wr_idx == IDX_OUT_DATA && wr_strb[0]) begin
        out_data[7:0] <= wr_data[7:0];
      end
      if (wr_idx == IDX_OUT_DATA && wr_strb[1]) begin
        out_data[8] <= wr_data[8];
      end
      if (wr_idx == IDX_INT_MASK && wr_strb[0]) begin
        int_mask <= wr_data[1:0];
      end
    end
  end

  // Read data; the reserved slot and unmapped space read as zero.
  always_comb begin
    rd_idx  = s_axi_araddr[8:2];
    rd_word = 32'h0;
    if (slot_of(rd_idx) != SLOT_NONE) begin
      rd_word[7:0] = cfg[slot_of(rd_idx)];
    end else if (rd_idx == IDX_OUT_DATA) begin
      rd_word[NPIN-1:0] = out_data;
    end else if (rd_idx == IDX_IN_STATE) begin
      rd_word[NPIN-1:0] = in_val;
    end else if (rd_idx == IDX_INT_STATUS) begin
      rd_word[1:0] = int_status;
    end else if (rd_idx == IDX_INT_MASK) begin
      rd_word[1:0] = int_mask;
    end
    if (s_axi_araddr[ADDR_W-1:9] != '0) begin
      rd_word = 32'h0;
    end
  end

  // Read channel: one read at a time, data one cycle after the address.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word; // RULE7
      s_axi_rresp   <= ((s_axi_araddr[ADDR_W-1:9] == '0) && is_mapped(rd_idx))
                       ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  sequence s_rsvd_read;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_W'({IDX_RESERVED, 2'b00});
  endsequence
  sequence s_zero_data;
    s_axi_rvalid && s_axi_rdata == 32'h0 && s_axi_rresp == RESP_OKAY;
  endsequence

  chk_reserved_read: assert property (s_rsvd_read |=> s_zero_data) // RULE7
    else $error("reserved slot read not zero");
  chk_no_alt_2_4: assert property (fn[SLOT_2_4] == PCB_FN_GPIO && // RULE8
    cfg[SLOT_2_4][BIT_SEL] == 1'b0)
    else $error("pin 2.4 has an alternate function");
  chk_floppy_select: assert property (fn[SLOT_2_1] == PCB_FN_FLOPPY && // RULE5
    !cfg[SLOT_2_1][BIT_OTYPE] |=> pin_out[SLOT_2_1] ==
    ($past(floppy_drive_select_one_n) ^ $past(cfg[SLOT_2_1][BIT_POL])))
    else $error("drive select not routed");
  chk_motor_select: assert property (fn[SLOT_2_2] == PCB_FN_FLOPPY && // RULE6
    !cfg[SLOT_2_2][BIT_OTYPE] |=> pin_out[SLOT_2_2] ==
    ($past(floppy_motor_select_one_n) ^ $past(cfg[SLOT_2_2][BIT_POL])))
    else $error("motor select not routed");
  chk_midi_transmit: assert property (fn[SLOT_2_6] != PCB_FN_GPIO && // RULE10
    !cfg[SLOT_2_6][BIT_OTYPE] |=> pin_out[SLOT_2_6] ==
    ($past(midi_transmit) ^ $past(cfg[SLOT_2_6][BIT_POL])))
    else $error("midi transmit not routed");
  chk_midi_receive: assert property (fn[SLOT_2_5] != PCB_FN_GPIO // RULE9
    |=> midi_receive == $past(in_val[SLOT_2_5]))
    else $error("midi receive not routed");
  chk_kbc_bit7: assert property (fn[SLOT_2_0] != PCB_FN_GPIO // RULE11
    |=> kbc_port_bit7_in == $past(in_val[SLOT_2_0]))
    else $error("keyboard bit seven not routed");
  chk_joystick_x: assert property (fn[SLOT_1_6] == PCB_FN_GPIO // RULE12
    |=> !joystick_two_x_axis)
    else $error("joystick x active while gpio");
  chk_joystick_y: assert property (fn[SLOT_1_7] != PCB_FN_GPIO // RULE13
    |=> joystick_two_y_axis == $past(in_val[SLOT_1_7]))
    else $error("joystick y not routed");
  chk_write_answer: assert property (wr_fire |=> s_axi_bvalid)
    else $error("write not answered");

endmodule // pcb_top

// ===== test/pcb_pad_model.sv
`timescale 1ns/1ns
// Board side of the bank: one pull-up per pad plus a bench-controlled
// pull-down driver, resolved against the device's own pad drivers.
module pcb_pad_model import pcb_pkg::*; (
  input  wire logic [NPIN-1:0] pin_out,
  input  wire logic [NPIN-1:0] pin_oe,
  input  wire logic [NPIN-1:0] ext_en,
  input  wire logic [NPIN-1:0] ext_val,
  output logic      [NPIN-1:0] pin_in
);
  // Wired-AND of all drivers; a released pad floats to its pull-up,
  // so it never keeps a stale value once nobody drives it.
  always_comb begin
    for (int i = 0; i < NPIN; i++) begin
      pin_in[i] = (pin_oe[i] ? pin_out[i] : 1'b1) & (ext_en[i] ? ext_val[i] : 1'b1);
    end
  end
endmodule // pcb_pad_model

// ===== test/testbench.sv
`timescale 1ns/1ns
// Compares two values, counts the comparison and reports a mismatch.
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_total++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module testbench import pcb_pkg::*;;
  logic            clk, nrst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic            s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic            s_axi_rvalid, s_axi_rready, irq;
  logic [11:0]     s_axi_awaddr, s_axi_araddr;
  logic [31:0]     s_axi_wdata, s_axi_rdata;
  logic [3:0]      s_axi_wstrb;
  logic [1:0]      s_axi_bresp, s_axi_rresp;
  logic [NPIN-1:0] pin_in, pin_out, pin_oe, ext_en, ext_val;
  logic            kbc_port_bit7_out, kbc_port_bit6_out, kbc_port_bit2_out, midi_transmit;
  logic            floppy_drive_select_one_n, floppy_motor_select_one_n, pin_2_7_alt_out;
  logic            kbc_port_bit7_in, kbc_port_bit6_in, kbc_port_bit2_in, midi_receive;
  logic            joystick_two_x_axis, joystick_two_y_axis, pin_2_7_alt_in;
  int              err_total, samples_checked, cycles;

  pcb_top i_pcb_top (.clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_in, .pin_out, .pin_oe,
    .kbc_port_bit7_out, .kbc_port_bit6_out, .kbc_port_bit2_out, .floppy_drive_select_one_n,
    .floppy_motor_select_one_n, .midi_transmit, .pin_2_7_alt_out, .kbc_port_bit7_in,
    .kbc_port_bit6_in, .kbc_port_bit2_in, .joystick_two_x_axis, .joystick_two_y_axis,
    .midi_receive, .pin_2_7_alt_in, .irq);
  pcb_pad_model i_pcb_pad_model (.pin_out, .pin_oe, .ext_en, .ext_val, .pin_in);

  // Free-running 50 ns clock.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Prints the verdict and ends the run.
  task automatic give_verdict;
    if (err_total == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // A hang costs a mismatch; the whole test needs far fewer cycles.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total++;
      give_verdict();
    end
  end

  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk);
  endtask

  // Bus write; address and data are released each at its own handshake.
  task automatic wr(input logic [6:0] idx, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    @(posedge clk);
    s_axi_awaddr <= {3'h0, idx, 2'b00};
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    `CHK(s_axi_bresp, er)
  endtask

  // Bus read; data and response are taken at the edge that sees rvalid.
  task automatic rd_chk(input logic [6:0] idx, input logic [31:0] e,
                        input logic [1:0] er = RESP_OKAY);
    @(posedge clk);
    s_axi_araddr <= {3'h0, idx, 2'b00};
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    `CHK(s_axi_rdata, e)
    `CHK(s_axi_rresp, er)
  endtask

  initial begin
    {nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, ext_en, ext_val} = '0;
    {err_total, samples_checked, cycles} = '0;
    // Peripheral drive levels are chosen to differ from the plain GPIO value 0.
    {kbc_port_bit7_out, kbc_port_bit6_out, kbc_port_bit2_out, pin_2_7_alt_out} = 4'hf;
    {floppy_drive_select_one_n, floppy_motor_select_one_n, midi_transmit} = 3'b111;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    // Defaults after reset: every pin an undriven GPIO input.
    for (int i = 0; i < NPIN; i++) rd_chk(PIN_IDX[i], 32'h01);
    `CHK({pin_oe, midi_receive}, 10'h001)
    rd_chk(IDX_RESERVED, 32'h0);
    // Reserved bits stay zero whatever is written.
    for (int i = 0; i < NPIN; i++) begin
      wr(PIN_IDX[i], 32'hff);
      rd_chk(PIN_IDX[i], 32'((i == SLOT_2_1 || i == SLOT_2_2) ? MASK_WIDE :
             (i == SLOT_2_4) ? MASK_NOALT : MASK_STD));
      wr(PIN_IDX[i], 32'h01);
    end
    wr(IDX_RESERVED, 32'hff);
    rd_chk(IDX_RESERVED, 32'h0);
    wr(7'h50, 32'h1, RESP_SLVERR);
    rd_chk(7'h50, 32'h0, RESP_SLVERR);
    // Pin 1.6 as output: direction, inversion and open drain.
    wr(IDX_OUT_DATA, 32'h1);
    wr(IDX_PIN_1_6, 32'h00);
    tick(2);
    `CHK({pin_oe[0], pin_out[0]}, 2'b11)
    wr(IDX_PIN_1_6, 32'h02);
    tick(2);
    `CHK({pin_oe[0], pin_out[0]}, 2'b10)
    wr(IDX_PIN_1_6, 32'h80);
    tick(2);
    `CHK(pin_oe[0], 1'b0)
    wr(IDX_OUT_DATA, 32'h0);
    tick(2);
    `CHK({pin_oe[0], pin_out[0]}, 2'b10)
    // As inverted input the pulled-up pad reads back as zero.
    wr(IDX_PIN_1_6, 32'h03);
    tick(4);
    `CHK(pin_oe[0], 1'b0)
    rd_chk(IDX_IN_STATE, 32'h1fe);
    // Input alternates; the MIDI pad is pulled low by the board.
    ext_en <= 9'h040;
    for (int i = 0; i < NPIN; i++) begin
      wr(PIN_IDX[i], (i > SLOT_2_2) && (i != SLOT_2_5) ? 32'h01 : 32'h05);
    end
    tick(4);
    `CHK({joystick_two_x_axis, joystick_two_y_axis, kbc_port_bit7_in}, 3'b111)
    `CHK({kbc_port_bit6_in, kbc_port_bit2_in, midi_receive}, 3'b110)
    `CHK(pin_2_7_alt_in, 1'b0)
    // Output alternates follow their peripherals, not the GPIO value.
    ext_en <= 9'h000;
    wr(IDX_PIN_2_1, 32'h0c);
    wr(IDX_PIN_2_2, 32'h0c);
    wr(IDX_PIN_2_6, 32'h04);
    tick(2);
    `CHK({pin_oe[7], pin_out[7], pin_oe[4], pin_out[4], pin_oe[3], pin_out[3]}, 6'h3f)
    // Keyboard routes drive the pads while the floppy selects show the other level.
    {floppy_drive_select_one_n, floppy_motor_select_one_n} <= 2'b00;
    wr(IDX_PIN_2_0, 32'h04);
    wr(IDX_PIN_2_1, 32'h04);
    wr(IDX_PIN_2_2, 32'h04);
    tick(2);
    `CHK({pin_oe[2], pin_out[2], pin_oe[3], pin_out[3]}, 4'hf)
    `CHK({pin_oe[4], pin_out[4]}, 2'b11)
    // Either-edge inputs: 2.2 masked, 2.1 enabled.
    wr(IDX_PIN_2_1, 32'h09);
    wr(IDX_PIN_2_2, 32'h09);
    wr(IDX_INT_STATUS, 32'h3);
    wr(IDX_INT_MASK, 32'h1);
    ext_en <= 9'h010;
    tick(5);
    `CHK(irq, 1'b0)
    rd_chk(IDX_INT_STATUS, 32'h2);
    ext_en <= 9'h018;
    tick(5);
    `CHK(irq, 1'b1)
    wr(IDX_INT_STATUS, 32'h1);
    rd_chk(IDX_INT_STATUS, 32'h2);
    `CHK(irq, 1'b0)
    // Rising edge counts as well.
    ext_en <= 9'h010;
    tick(5);
    `CHK(irq, 1'b1)
    wr(IDX_INT_MASK, 32'h0);
    tick(2);
    `CHK(irq, 1'b0)
    give_verdict();
  end
endmodule // testbench
